// File: pkg/psmb_cfg.svh
// Constants for the power controller serial link: addresses, offsets, fields and timing.
`ifndef PSMB_CFG_SVH
`define PSMB_CFG_SVH
`define PSMB_ADDR_HI      3'h2
`define PSMB_ADDR_GLOBAL  7'h30
`define PSMB_ADDR_ALERT   7'h0C
`define PSMB_PTR_W        5
`define PSMB_PTR_RST      5'h00
`define PSMB_CLK_HZ       125000000
`define PSMB_SCL_HZ       100000
`define PSMB_QTR_CYC      (`PSMB_CLK_HZ / (4 * `PSMB_SCL_HZ))
`define PSMB_OFS_CTRL     8'h00
`define PSMB_OFS_STAT     8'h04
`define PSMB_OFS_IRQ_STAT 8'h08
`define PSMB_OFS_IRQ_MASK 8'h0C
`define PSMB_CTRL_OP_LSB  0
`define PSMB_CTRL_AD_LSB  8
`define PSMB_CTRL_CMD_LSB 16
`define PSMB_CTRL_DAT_LSB 24
`define PSMB_STAT_RX_LSB  8
`define PSMB_IRQ_DONE     0
`define PSMB_IRQ_NACK     1
`define PSMB_IRQ_ALERT    2
`define PSMB_IRQ_RST      3'h0
`endif

// File: pkg/psmb_pkg.sv
// Types for the two ends of the power controller serial link: device states, host bit states and operations.
package psmb_pkg;
  typedef enum logic [3:0] {
    D_IDLE  = 4'b0000,
    D_ADDR  = 4'b0001,
    D_ACK_A = 4'b0010,
    D_CMD   = 4'b0011,
    D_ACK_C = 4'b0100,
    D_DATA  = 4'b0101,
    D_ACK_D = 4'b0110,
    D_TX    = 4'b0111,
    D_RACK  = 4'b1000
  } psmb_dev_st_e;
  typedef enum logic [1:0] {
    B_IDLE  = 2'b00,
    B_START = 2'b01,
    B_BIT   = 2'b10,
    B_STOP  = 2'b11
  } psmb_bit_st_e;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_WR   = 2'b01,
    OP_RD   = 2'b10,
    OP_RX   = 2'b11
  } psmb_op_e;
endpackage

// File: pkg/psmb_if.sv
// Serial link carrier: resolves the open-drain clock, data and interrupt lines.
`timescale 1ns/1ps
interface psmb_if;
  logic host_scl_oe_n;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic dev_int_oe_n;
  logic scl;
  logic sda;
  logic int_n;
  assign scl   = host_scl_oe_n;
  assign sda   = host_sda_oe_n & dev_sda_oe_n;
  assign int_n = dev_int_oe_n;
  modport dev  (input scl, input sda, output dev_sda_oe_n, output dev_int_oe_n);
  modport host (input scl, input sda, input int_n, output host_scl_oe_n, output host_sda_oe_n);
endinterface

// File: hdl/psmb_dev.sv
// Device end of the serial link: address match, pointer, register access and alert line.
//
// Added by the designer: the register file access port (address, write data, write strobe).
`timescale 1ns/1ps
`include "psmb_cfg.svh"
module psmb_dev (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   srst_i,
  // Serial link
  psmb_if.dev                         link,
  // Straps and event source
  input  wire logic [3:0]             addr_sel_i,
  input  wire logic                   event_pending_i,
  // Register file access
  input  wire logic [7:0]             reg_rdata_i,
  output logic      [`PSMB_PTR_W-1:0] reg_addr_o,
  output logic      [7:0]             reg_wdata_o,
  output logic                        reg_wr_o
);
  psmb_pkg::psmb_dev_st_e st, next_st;
  logic [2:0]             scl_s;
  logic [2:0]             sda_s;
  logic [3:0]             ad_m;
  logic [3:0]             ad_q;
  logic [3:0]             bitcnt, next_bitcnt;
  logic [7:0]             sh, next_sh;
  logic [`PSMB_PTR_W-1:0] next_ptr;
  logic [7:0]             next_wdata;
  logic                   next_wr;
  logic                   rw, next_rw;
  logic                   ara, next_ara;
  logic                   sda_oe_n, next_sda_oe_n;
  logic                   int_oe_n, next_int_oe_n;
  logic                   busy, next_busy;
  logic                   int_blk, next_int_blk;
  logic                   scl_r, scl_f, start_c, stop_c;
  logic [6:0]             own_addr;
  logic [6:0]             rx_addr;
  logic                   hit_pri, hit_glb, hit_ara;

  // Stage 0 of each synchroniser feeds stage 1 only; edges are seen between stages 1 and 2.
  assign scl_r    = scl_s[1] & ~scl_s[2];
  assign scl_f    = ~scl_s[1] & scl_s[2];
  assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  assign own_addr = {`PSMB_ADDR_HI, ad_q};
  assign rx_addr  = sh[7:1];
  assign hit_pri  = rx_addr == own_addr;
  assign hit_glb  = rx_addr == `PSMB_ADDR_GLOBAL;
  assign hit_ara  = (rx_addr == `PSMB_ADDR_ALERT) & sh[0] & ~int_oe_n;

  always_comb begin
    next_st       = st;
    next_bitcnt   = bitcnt;
    next_sh       = sh;
    next_ptr      = reg_addr_o;
    next_wdata    = reg_wdata_o;
    next_wr       = 1'b0;
    next_rw       = rw;
    next_ara      = ara;
    next_sda_oe_n = sda_oe_n;
    next_busy     = busy;
    if (stop_c) begin
      next_st       = psmb_pkg::D_IDLE;
      next_ptr      = `PSMB_PTR_RST;
      next_busy     = 1'b0;
      next_sda_oe_n = 1'b1;
    end else if (start_c) begin
      // A repeated START lands here too and keeps the pointer for the read that follows.
      next_st       = psmb_pkg::D_ADDR;
      next_bitcnt   = 4'h0;
      next_busy     = 1'b1;
      next_sda_oe_n = 1'b1;
      next_ara      = 1'b0;
    end else if (scl_r) begin
      unique case (st)
        psmb_pkg::D_ADDR, psmb_pkg::D_CMD, psmb_pkg::D_DATA: begin
          next_sh     = {sh[6:0], sda_s[1]};
          next_bitcnt = bitcnt + 4'h1;
        end
        psmb_pkg::D_TX: begin
          if (ara && sda_oe_n && !sda_s[1]) begin
            next_st = psmb_pkg::D_IDLE;
          end
        end
        psmb_pkg::D_RACK: begin
          next_sh[0] = sda_s[1];
        end
        default: begin
        end
      endcase
    end else if (scl_f) begin
      unique case (st)
        psmb_pkg::D_ADDR: begin
          if (bitcnt == 4'h8) begin
            if (hit_pri || hit_glb || hit_ara) begin
              next_sda_oe_n = 1'b0;
              next_rw       = sh[0];
              next_ara      = hit_ara;
              next_st       = psmb_pkg::D_ACK_A;
            end else begin
              next_st = psmb_pkg::D_IDLE;
            end
          end
        end
        psmb_pkg::D_ACK_A: begin
          next_bitcnt = 4'h1;
          if (rw) begin
            // With the pointer cleared by every STOP, a bare read returns register zero.
            next_sh       = ara ? {own_addr, 1'b1} : reg_rdata_i;
            next_sda_oe_n = next_sh[7];
            next_st       = psmb_pkg::D_TX;
          end else begin
            next_bitcnt   = 4'h0;
            next_sda_oe_n = 1'b1;
            next_st       = psmb_pkg::D_CMD;
          end
        end
        psmb_pkg::D_CMD: begin
          if (bitcnt == 4'h8) begin
            next_ptr      = sh[`PSMB_PTR_W-1:0];
            next_sda_oe_n = 1'b0;
            next_st       = psmb_pkg::D_ACK_C;
          end
        end
        psmb_pkg::D_ACK_C: begin
          next_bitcnt   = 4'h0;
          next_sda_oe_n = 1'b1;
          next_st       = psmb_pkg::D_DATA;
        end
        psmb_pkg::D_DATA: begin
          if (bitcnt == 4'h8) begin
            next_wdata    = sh;
            next_wr       = 1'b1;
            next_sda_oe_n = 1'b0;
            next_st       = psmb_pkg::D_ACK_D;
          end
        end
        psmb_pkg::D_ACK_D: begin
          // Bytes beyond one data byte are not acknowledged.
          next_sda_oe_n = 1'b1;
          next_st       = psmb_pkg::D_IDLE;
        end
        psmb_pkg::D_TX: begin
          if (bitcnt == 4'h8) begin
            next_sda_oe_n = 1'b1;
            next_st       = psmb_pkg::D_RACK;
          end else begin
            next_sda_oe_n = sh[6];
            next_sh       = {sh[6:0], 1'b1};
            next_bitcnt   = bitcnt + 4'h1;
          end
        end
        psmb_pkg::D_RACK: begin
          if (!sh[0] && !ara) begin
            next_sh       = reg_rdata_i;
            next_sda_oe_n = reg_rdata_i[7];
            next_bitcnt   = 4'h1;
            next_st       = psmb_pkg::D_TX;
          end else begin
            next_st = psmb_pkg::D_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // The alert block is set on a completed alert reply and lifted once the cause is gone; set wins.
  always_comb begin
    next_int_blk  = (scl_f && st == psmb_pkg::D_RACK && ara) | (int_blk & event_pending_i);
    next_int_oe_n = int_oe_n;
    if (!busy) begin
      next_int_oe_n = ~(event_pending_i & ~int_blk);
    end
  end

  always_ff @(posedge core_clk_i) begin
    scl_s <= {scl_s[1:0], link.scl};
    sda_s <= {sda_s[1:0], link.sda};
    ad_m  <= addr_sel_i;
    ad_q  <= ad_m;
    if (srst_i) begin
      st                <= psmb_pkg::D_IDLE;
      bitcnt            <= 4'h0;
      sh                <= 8'h00;
      reg_addr_o        <= `PSMB_PTR_RST;
      reg_wdata_o       <= 8'h00;
      reg_wr_o          <= 1'b0;
      rw                <= 1'b0;
      ara               <= 1'b0;
      sda_oe_n          <= 1'b1;
      int_oe_n          <= 1'b1;
      busy              <= 1'b0;
      int_blk           <= 1'b0;
      link.dev_sda_oe_n <= 1'b1;
      link.dev_int_oe_n <= 1'b1;
    end else begin
      st                <= next_st;
      bitcnt            <= next_bitcnt;
      sh                <= next_sh;
      reg_addr_o        <= next_ptr;
      reg_wdata_o       <= next_wdata;
      reg_wr_o          <= next_wr;
      rw                <= next_rw;
      ara               <= next_ara;
      sda_oe_n          <= next_sda_oe_n;
      int_oe_n          <= next_int_oe_n;
      busy              <= next_busy;
      int_blk           <= next_int_blk;
      link.dev_sda_oe_n <= next_sda_oe_n;
      link.dev_int_oe_n <= next_int_oe_n;
    end
  end
endmodule

// File: hdl/psmb_host.sv
// Host end of the serial link: APB-driven master issuing write, read and receive byte transfers.
`timescale 1ns/1ps
`include "psmb_cfg.svh"
module psmb_host #(
  parameter int QTR_CYC = `PSMB_QTR_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // APB slave and interrupt
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  // Serial link
  psmb_if.host             link
);
  psmb_pkg::psmb_bit_st_e bst, next_bst;
  psmb_pkg::psmb_op_e     op, next_op;
  logic [15:0] qcnt;
  logic        tick;
  logic [1:0]  q, next_q;
  logic [2:0]  step, next_step;
  logic [3:0]  bitn, next_bitn;
  logic [7:0]  sh, next_sh;
  logic [6:0]  taddr, next_taddr;
  logic [7:0]  tcmd, next_tcmd, tdat, next_tdat, rx, next_rx;
  logic        nack, next_nack, scl_oe_n, next_scl_oe_n, sda_oe_n, next_sda_oe_n;
  logic [2:0]  ist, next_ist, imask, next_imask;
  logic [2:0]  sda_s, int_s;
  logic        acc, wr_en, hit, ev_done, ev_nack, ev_alert, rd_byte, load;
  logic        rd_act;
  psmb_pkg::psmb_bit_st_e la;
  logic [7:0]  lb;
  logic        lr;
  logic [31:0] rdv;

  assign tick     = qcnt == 16'h0000;
  assign acc      = psel_i & penable_i;
  assign wr_en    = acc & pready_o & pwrite_i;
  assign ev_alert = ~int_s[1] & int_s[2];

  // Action sequence per operation; direction changes use a repeated START, never a STOP.
  always_comb begin
    la = psmb_pkg::B_STOP;
    lb = 8'h00;
    lr = 1'b0;
    unique case ({op, next_step})
      {psmb_pkg::OP_WR, 3'h0}, {psmb_pkg::OP_RD, 3'h0}, {psmb_pkg::OP_RX, 3'h0}: la = psmb_pkg::B_START;
      {psmb_pkg::OP_WR, 3'h1}, {psmb_pkg::OP_RD, 3'h1}: begin la = psmb_pkg::B_BIT; lb = {taddr, 1'b0}; end
      {psmb_pkg::OP_WR, 3'h2}, {psmb_pkg::OP_RD, 3'h2}: begin la = psmb_pkg::B_BIT; lb = tcmd; end
      {psmb_pkg::OP_WR, 3'h3}: begin la = psmb_pkg::B_BIT; lb = tdat; end
      {psmb_pkg::OP_RD, 3'h3}: la = psmb_pkg::B_START;
      {psmb_pkg::OP_RD, 3'h4}, {psmb_pkg::OP_RX, 3'h1}: begin la = psmb_pkg::B_BIT; lb = {taddr, 1'b1}; end
      {psmb_pkg::OP_RD, 3'h5}, {psmb_pkg::OP_RX, 3'h2}: begin la = psmb_pkg::B_BIT; lr = 1'b1; end
      default: la = psmb_pkg::B_STOP;
    endcase
  end

  assign rd_act = (op == psmb_pkg::OP_RD && step == 3'h5) || (op == psmb_pkg::OP_RX && step == 3'h2);

  always_comb begin
    next_bst = bst; next_op = op; next_q = q; next_step = step; next_bitn = bitn; next_sh = sh;
    next_rx = rx; next_nack = nack; next_scl_oe_n = scl_oe_n; next_sda_oe_n = sda_oe_n;
    next_taddr = taddr; next_tcmd = tcmd; next_tdat = tdat;
    ev_done = 1'b0; ev_nack = 1'b0; load = 1'b0;
    if (bst == psmb_pkg::B_IDLE) begin
      if (wr_en && paddr_i == `PSMB_OFS_CTRL && pwdata_i[1:0] != 2'b00) begin
        next_op    = psmb_pkg::psmb_op_e'(pwdata_i[`PSMB_CTRL_OP_LSB +: 2]);
        next_taddr = pwdata_i[`PSMB_CTRL_AD_LSB +: 7];
        next_tcmd  = pwdata_i[`PSMB_CTRL_CMD_LSB +: 8];
        next_tdat  = pwdata_i[`PSMB_CTRL_DAT_LSB +: 8];
        next_nack  = 1'b0;
        next_step  = 3'h0;
        next_bst   = psmb_pkg::B_START;
        next_q     = 2'h0;
      end
    end else if (tick) begin
      next_q = q + 2'h1;
      unique case (bst)
        psmb_pkg::B_START: begin
          unique case (q)
            2'h0: next_sda_oe_n = 1'b1;
            2'h1: next_scl_oe_n = 1'b1;
            2'h2: next_sda_oe_n = 1'b0;
            2'h3: begin next_scl_oe_n = 1'b0; load = 1'b1; end
          endcase
        end
        psmb_pkg::B_BIT: begin
          unique case (q)
            // On the ninth bit of a read the line is left released: a single byte is always the last.
            2'h0: next_sda_oe_n = rd_act | (bitn == 4'h8) | sh[7];
            2'h1: next_scl_oe_n = 1'b1;
            2'h2: begin
              if (bitn != 4'h8) next_sh = {sh[6:0], sda_s[1]};
              else if (!rd_act) next_nack = sda_s[1];
            end
            2'h3: begin
              next_scl_oe_n = 1'b0;
              next_bitn     = bitn + 4'h1;
              if (bitn == 4'h8) begin
                if (rd_act) next_rx = sh;
                if (nack) begin
                  next_bst = psmb_pkg::B_STOP;
                  ev_nack  = 1'b1;
                end else begin
                  load = 1'b1;
                end
              end
            end
          endcase
        end
        psmb_pkg::B_STOP: begin
          unique case (q)
            2'h0: next_sda_oe_n = 1'b0;
            2'h1: next_scl_oe_n = 1'b1;
            2'h2: next_sda_oe_n = 1'b1;
            2'h3: begin next_bst = psmb_pkg::B_IDLE; ev_done = 1'b1; end
          endcase
        end
        default: begin
        end
      endcase
      if (load) begin
        next_step = step + 3'h1;
        next_bst  = la;
        next_sh   = lb;
        next_bitn = 4'h0;
        next_q    = 2'h0;
      end
    end
  end

  // Status bits are sticky and cleared by writing one; a new event beats a clear in the same cycle.
  always_comb begin
    next_imask = imask;
    next_ist   = ist;
    if (wr_en && paddr_i == `PSMB_OFS_IRQ_STAT) next_ist = ist & ~pwdata_i[2:0];
    if (wr_en && paddr_i == `PSMB_OFS_IRQ_MASK) next_imask = pwdata_i[2:0];
    next_ist = next_ist | {ev_alert, ev_nack, ev_done};
  end

  always_comb begin
    hit = 1'b1;
    rdv = 32'h0000_0000;
    unique case (paddr_i)
      `PSMB_OFS_CTRL:     rdv = {tdat, tcmd, 1'b0, taddr, 6'h00, op};
      `PSMB_OFS_STAT:     rdv = {16'h0000, rx, 5'h00, ~int_s[1], nack, bst != psmb_pkg::B_IDLE};
      `PSMB_OFS_IRQ_STAT: rdv = {29'h0000_0000, ist};
      `PSMB_OFS_IRQ_MASK: rdv = {29'h0000_0000, imask};
      default:            hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    sda_s <= {sda_s[1:0], link.sda};
    int_s <= {int_s[1:0], link.int_n};
    if (srst_i) begin
      qcnt <= 16'h0000; bst <= psmb_pkg::B_IDLE; op <= psmb_pkg::OP_NONE; q <= 2'h0; step <= 3'h0;
      bitn <= 4'h0; sh <= 8'h00; rx <= 8'h00; nack <= 1'b0; scl_oe_n <= 1'b1; sda_oe_n <= 1'b1;
      taddr <= 7'h00; tcmd <= 8'h00; tdat <= 8'h00; ist <= `PSMB_IRQ_RST; imask <= `PSMB_IRQ_RST;
      prdata_o <= 32'h0000_0000; pready_o <= 1'b0; pslverr_o <= 1'b0; irq_o <= 1'b0;
      link.host_scl_oe_n <= 1'b1; link.host_sda_oe_n <= 1'b1;
    end else begin
      qcnt <= tick ? 16'(QTR_CYC - 1) : qcnt - 16'h0001;
      bst <= next_bst; op <= next_op; q <= next_q; step <= next_step;
      bitn <= next_bitn; sh <= next_sh; rx <= next_rx; nack <= next_nack;
      scl_oe_n <= next_scl_oe_n; sda_oe_n <= next_sda_oe_n;
      taddr <= next_taddr; tcmd <= next_tcmd; tdat <= next_tdat; ist <= next_ist; imask <= next_imask;
      pready_o  <= acc & ~pready_o;
      prdata_o  <= (acc & ~pready_o & ~pwrite_i & hit) ? rdv : 32'h0000_0000;
      pslverr_o <= acc & ~pready_o & ~hit;
      irq_o     <= |(next_ist & next_imask);
      link.host_scl_oe_n <= next_scl_oe_n;
      link.host_sda_oe_n <= next_sda_oe_n;
    end
  end
endmodule

// File: verification/psmb_link_monitor.sv
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/1ps
module psmb_link_monitor #(
  parameter int QTR_CYC = 10
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Link signals
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic dev_int_oe_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n
);
  logic        scl_q;
  logic        sda_q;
  logic        in_frame;
  logic        next_in_frame;
  logic [15:0] hi_cnt;
  logic [15:0] next_hi_cnt;
  logic        start_c;
  logic        stop_c;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;
  always_comb begin
    next_in_frame = start_c ? 1'b1 : (stop_c ? 1'b0 : in_frame);
    next_hi_cnt   = (scl && hi_cnt != 16'hFFFF) ? hi_cnt + 16'h0001 : (scl ? hi_cnt : 16'h0000);
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      hi_cnt   <= 16'h0000;
    end else begin
      scl_q    <= scl;
      sda_q    <= sda;
      in_frame <= next_in_frame;
      hi_cnt   <= next_hi_cnt;
    end
  end
  default clocking mon_cb @(posedge core_clk_i); endclocking
  // Reset must leave every open-drain line released, whatever state it interrupted.
  rst_release_a: assert property (disable iff (1'b0) srst_i |=> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n && dev_int_oe_n)
    else $error("link lines not released after reset");
  idle_high_a: assert property (disable iff (srst_i) !in_frame && !start_c |-> scl && sda)
    else $error("bus not high while idle");
  scl_frame_a: assert property (disable iff (srst_i) !host_scl_oe_n |-> in_frame)
    else $error("clock driven low outside a frame");
  // The device sees the wire through synchronisers, so allow a few cycles after START.
  int_frame_a: assert property (disable iff (srst_i) in_frame && $past(in_frame, 6) |-> $stable(int_n))
    else $error("interrupt line changed inside a transaction");
  dev_idle_a: assert property (disable iff (srst_i) !in_frame && !$past(in_frame, 6) |-> dev_sda_oe_n)
    else $error("device drives data on a free bus");
  scl_steady_a: assert property (disable iff (srst_i) in_frame && scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("device data changed while clock high");
  dev_change_a: assert property (disable iff (srst_i) $changed(dev_sda_oe_n) |-> !scl [*4])
    else $error("device data changed too close to clock rise");
  scl_width_a: assert property (disable iff (srst_i) $fell(scl) |-> hi_cnt >= 16'(QTR_CYC))
    else $error("clock high phase too short");
endmodule

// File: verification/tb_top.sv
// Self-checking bench joining the host and device ends of the serial link.
`timescale 1ns/1ps
`include "psmb_cfg.svh"
module tb_top;
  typedef struct packed {
    psmb_pkg::psmb_op_e op;
    logic [6:0]         a;
    logic [7:0]         c;
    logic [7:0]         d;
    logic               nack;
    logic [7:0]         rx;
  } psmb_row_s;
  logic        core_clk      = 1'b0;
  logic        srst          = 1'b1;
  logic [7:0]  paddr         = 8'h00;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [31:0] pwdata        = 32'h0;
  logic [3:0]  addr_sel      = 4'hA;
  logic        event_pending = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic [7:0]  regs [32];
  logic [31:0] st;
  logic [31:0] r;
  logic        err;
  int          failures = 0;
  int          n_checks = 0;
  psmb_row_s   rows [8];
  always #4 core_clk = ~core_clk;
  psmb_if u_psmb_if ();
  psmb_host #(.QTR_CYC(10)) u_psmb_host (.core_clk_i(core_clk), .srst_i(srst), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .link(u_psmb_if.host));
  psmb_dev u_psmb_dev (.core_clk_i(core_clk), .srst_i(srst), .link(u_psmb_if.dev), .addr_sel_i(addr_sel),
    .event_pending_i(event_pending), .reg_rdata_i(regs[reg_addr]), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr));
  psmb_link_monitor #(.QTR_CYC(10)) u_psmb_link_monitor (.core_clk_i(core_clk), .srst_i(srst),
    .host_scl_oe_n(u_psmb_if.host_scl_oe_n), .host_sda_oe_n(u_psmb_if.host_sda_oe_n),
    .dev_sda_oe_n(u_psmb_if.dev_sda_oe_n), .dev_int_oe_n(u_psmb_if.dev_int_oe_n),
    .scl(u_psmb_if.scl), .sda(u_psmb_if.sda), .int_n(u_psmb_if.int_n));
  // Register 0 is the read-only event summary, so writes aimed at it are dropped.
  always @(posedge core_clk) if (reg_wr && reg_addr != 5'h00) regs[reg_addr] <= reg_wdata;
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask
  // Waits for pready with no cycle limit of its own; a hang is ended by the watchdog.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xfer(input psmb_row_s w);
    apb(1'b1, `PSMB_OFS_CTRL, {w.d, w.c, 1'b0, w.a, 6'h00, w.op});
    do begin
      apb(1'b0, `PSMB_OFS_STAT, 32'h0);
    end while (r[0] !== 1'b0);
    st = r;
  endtask
  task automatic wait_int(input logic e);
    int n;
    n = 0;
    while (u_psmb_if.int_n !== e && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk_bit(u_psmb_if.int_n, e);
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The whole run is about 10000 cycles of link traffic; the watchdog fires at 60000.
  initial begin
    #480000;
    failures++;
    print_verdict();
  end
  initial begin
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'h40 + 8'(i);
    end
    rows[0] = '{psmb_pkg::OP_WR, 7'h2A, 8'hE5, 8'h3C, 1'b0, 8'h00};
    rows[1] = '{psmb_pkg::OP_RD, 7'h2A, 8'h05, 8'h00, 1'b0, 8'h3C};
    rows[2] = '{psmb_pkg::OP_RX, 7'h2A, 8'h00, 8'h00, 1'b0, 8'h40};
    rows[3] = '{psmb_pkg::OP_WR, 7'h30, 8'h07, 8'h99, 1'b0, 8'h00};
    rows[4] = '{psmb_pkg::OP_RD, 7'h30, 8'h07, 8'h00, 1'b0, 8'h99};
    rows[5] = '{psmb_pkg::OP_RD, 7'h2A, 8'hFF, 8'h00, 1'b0, 8'h5F};
    rows[6] = '{psmb_pkg::OP_WR, 7'h2B, 8'h01, 8'h11, 1'b1, 8'h00};
    rows[7] = '{psmb_pkg::OP_RX, 7'h0C, 8'h00, 8'h00, 1'b1, 8'h00};
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      xfer(rows[i]);
      chk_bit(st[1], rows[i].nack);
      if (rows[i].op != psmb_pkg::OP_WR && !rows[i].nack) begin
        chk_word({24'h0, st[15:8]}, {24'h0, rows[i].rx});
      end
    end
    chk_word({24'h0, regs[5]}, 32'h3C);
    chk_bit(irq, 1'b0);
    apb(1'b1, `PSMB_OFS_IRQ_MASK, 32'h1);
    apb(1'b0, `PSMB_OFS_IRQ_STAT, 32'h0);
    chk_word(r, 32'h3);
    chk_bit(irq, 1'b1);
    apb(1'b1, `PSMB_OFS_IRQ_STAT, 32'h1);
    apb(1'b0, `PSMB_OFS_IRQ_STAT, 32'h0);
    chk_word(r, 32'h2);
    chk_bit(irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk_bit(err, 1'b1);
    chk_word(r, 32'h0);
    event_pending <= 1'b1;
    wait_int(1'b0);
    apb(1'b0, `PSMB_OFS_IRQ_STAT, 32'h0);
    chk_bit(r[2], 1'b1);
    xfer('{psmb_pkg::OP_RX, 7'h0C, 8'h00, 8'h00, 1'b0, 8'h00});
    chk_bit(st[1], 1'b0);
    chk_word({24'h0, st[15:8]}, 32'h55);
    repeat (300) @(posedge core_clk);
    chk_bit(u_psmb_if.int_n, 1'b1);
    event_pending <= 1'b0;
    @(posedge core_clk);
    event_pending <= 1'b1;
    wait_int(1'b0);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk_word({27'h0, reg_addr}, 32'h0);
    apb(1'b0, `PSMB_OFS_IRQ_MASK, 32'h0);
    chk_word(r, 32'h0);
    chk_bit(irq, 1'b0);
    print_verdict();
  end
endmodule
